//--- src/packet_client_loopback_ctrl.v
`timescale 1ns/1ps
`include "pkt_client_consts.vh"

// What this block does
// - The packet generator is stopped while control bit 1 is one and runs while it is zero.
// - Writing zero to the generator disable bit turns generation back on at run time.
// - Control bit 3 reads one while the client loops MAC receive traffic back to transmit, else zero.
// - Error bit 0 is set on a loopback FIFO underflow and stays set until software clears it.
// - Error bit 1 is set on a loopback FIFO overflow and stays set until software clears it.
// - Software writing one to error bit 2 returns to zero each sticky flag that sees no new event in that cycle.
// - While loopback reset bit 0 is one the loopback path and its FIFO are held in reset; it resets to zero.
module packet_client_loopback_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [17:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        loopback_mode,
	input  wire        fifo_underflow,
	input  wire        fifo_overflow,
	output wire        generator_enable,
	output wire        loopback_reset
);

	// Register map in short
	//   Control word: bit 0 fixed one, bit 1 generator disable, bit 2 fixed one,
	//   bit 3 shows the loopback mode input; only bit 1 is writable
	//   Error word: bit 0 underflow, bit 1 overflow, both sticky;
	//   bit 2 is a write-only clear strobe and always reads zero
	//   Loopback reset word: bit 0 holds the loopback path in reset
	// Unmapped words read zero, ignore writes and raise the slave error

	// Stored register state
	reg  [3:0]  tx_generator_control;
	reg  [1:0]  err_flags;
	reg         loopback_path_reset;

	// Next values of the sticky flags
	reg         next_underflow;
	reg         next_overflow;

	// Next value of the read data register
	reg  [31:0] next_prdata;

	// Word index of a byte address; every register is one aligned word
	function [15:0] word_index;
		input [17:0] byte_addr;
		begin
			word_index = byte_addr[17:2];
		end
	endfunction

	// One when a word index belongs to this block
	function is_mapped;
		input [15:0] idx;
		begin
			is_mapped = (idx == `IDX_TX_GENERATOR_CONTROL)
				| (idx == `IDX_LOOPBACK_FIFO_ERROR)
				| (idx == `IDX_LOOPBACK_PATH_RESET);
		end
	endfunction

	// Read value of one word; the mode bit is live, never stored
	function [31:0] read_word;
		input [15:0] idx;
		input        mode;
		input [3:0]  ctrl;
		input [1:0]  flags;
		input        lbr;
		begin
			if (idx == `IDX_TX_GENERATOR_CONTROL) begin
				read_word = {28'h0000000, mode, ctrl[2:0]};
			end else if (idx == `IDX_LOOPBACK_FIFO_ERROR) begin
				read_word = {30'h00000000, flags}; // Clear bit reads as zero
			end else if (idx == `IDX_LOOPBACK_PATH_RESET) begin
				read_word = {31'h00000000, lbr};
			end else begin
				read_word = 32'h00000000;
			end
		end
	endfunction

	// Sticky flag update; the event term is not masked by the clear, so a set beats a clear
	function sticky_next;
		input event_seen;
		input held;
		input clear;
		input path_in_reset;
		begin
			sticky_next = (event_seen & ~path_in_reset) | (held & ~clear);
		end
	endfunction

	// Bus decode
	wire [15:0] index     = word_index(paddr);
	wire        access    = psel & penable;
	wire        setup_rd  = psel & ~penable & ~pwrite;
	wire        wr        = access & pwrite & pstrb[0];
	wire        hit_txc   = (index == `IDX_TX_GENERATOR_CONTROL);
	wire        hit_err   = (index == `IDX_LOOPBACK_FIFO_ERROR);
	wire        hit_lbr   = (index == `IDX_LOOPBACK_PATH_RESET);
	wire        mapped    = is_mapped(index);
	wire        err_clear = wr & hit_err & pwdata[`ERR_CLEAR_BIT];

	// Zero wait states; an unmapped word answers with an error
	// Trade-off: no wait states means the read word must be ready at setup
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// Generator runs while the disable bit is zero
	assign generator_enable = ~tx_generator_control[`TXC_GEN_DISABLE_BIT];
	assign loopback_reset   = loopback_path_reset;

	// Generator disable bit; the other control bits keep their reset value
	// A write with byte strobe 0 low leaves the bit alone
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_generator_control <= `TXC_RESET_VALUE;
		end else begin
			if (wr && hit_txc) begin
				tx_generator_control[`TXC_GEN_DISABLE_BIT] <= pwdata[`TXC_GEN_DISABLE_BIT];
			end
		end
	end

	// Loopback path reset bit, held until software writes it again
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loopback_path_reset <= `LBR_RESET_VALUE;
		end else begin
			if (wr && hit_lbr) begin
				loopback_path_reset <= pwdata[`LBR_RESET_BIT];
			end
		end
	end

	// Next sticky flag values
	// A FIFO held in reset cannot err, so its events are ignored then
	always @* begin
		next_underflow = sticky_next(fifo_underflow,
			err_flags[`ERR_UNDERFLOW_BIT], err_clear, loopback_path_reset);
		next_overflow  = sticky_next(fifo_overflow,
			err_flags[`ERR_OVERFLOW_BIT], err_clear, loopback_path_reset);
	end

	// Sticky flags: a new event in the clearing cycle wins so it is not lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_flags <= `ERR_RESET_VALUE_FLAGS;
		end else begin
			err_flags[`ERR_UNDERFLOW_BIT] <= next_underflow;
			err_flags[`ERR_OVERFLOW_BIT]  <= next_overflow;
		end
	end

	// Next read data; loaded only in the setup cycle of a read
	always @* begin
		next_prdata = prdata;
		if (setup_rd) begin
			next_prdata = read_word(index, loopback_mode, tx_generator_control,
				err_flags, loopback_path_reset);
		end
	end

	// Read data registered during setup so it stands through the access phase
	// Limitation: an event in the setup cycle shows only on the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule // packet_client_loopback_ctrl

//--- src/pkt_client_consts.vh
`ifndef PKT_CLIENT_CONSTS_VH
`define PKT_CLIENT_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_TX_GENERATOR_CONTROL     16'h1010
`define IDX_LOOPBACK_FIFO_ERROR      16'h1015
`define IDX_LOOPBACK_PATH_RESET      16'h1016

// Field positions
`define TXC_GEN_DISABLE_BIT          1
`define TXC_LOOPBACK_MODE_BIT        3
`define ERR_UNDERFLOW_BIT            0
`define ERR_OVERFLOW_BIT             1
`define ERR_CLEAR_BIT                2
`define LBR_RESET_BIT                0

// Reset values
`define TXC_RESET_VALUE              4'h5
`define ERR_RESET_VALUE              3'h0
`define LBR_RESET_VALUE              1'h0
`define ERR_RESET_VALUE_FLAGS        2'h0

`endif

//--- test/loop_path.sv
`timescale 1ns/1ps
module loop_path(input wire pclk,input wire loopback_reset,output reg loopback_mode,fifo_underflow,fifo_overflow);
initial {loopback_mode,fifo_underflow,fifo_overflow}=3'h0;
// One-cycle FIFO error; a FIFO held in reset cannot err
task ev(input o);
	@(posedge pclk);
	if (!loopback_reset) {fifo_overflow,fifo_underflow}<={o,!o};
	@(posedge pclk);
	{fifo_overflow,fifo_underflow}<=2'h0;
endtask
endmodule // loop_path

//--- test/packet_client_loopback_ctrl_bench.sv
`timescale 1ns/1ps
module packet_client_loopback_ctrl_bench;
reg pclk=0,presetn=0,psel=0,penable=0,pwrite=0;
reg [17:0] paddr=0;
reg [31:0] pwdata=0,q;
wire lm,fu,fo,ge,lr,pready,slv;
reg [3:0] pstrb=4'hF;
reg s;
wire [31:0] prdata;
integer miscompares=0,check_count=0;
always #25 pclk=~pclk;
packet_client_loopback_ctrl uut(.pclk,.presetn,.psel,.penable,.pwrite,.paddr,.pwdata,.pstrb,.pready,.prdata,
	.pslverr(slv),.loopback_mode(lm),.fifo_underflow(fu),.fifo_overflow(fo),.generator_enable(ge),.loopback_reset(lr));
loop_path lp(.pclk,.loopback_reset(lr),.loopback_mode(lm),.fifo_underflow(fu),.fifo_overflow(fo));
task c(input [31:0] g,e);
	check_count++;
	if (g!==e) begin miscompares++;$display("BAD %0t %h!=%h",$time,g,e);end
endtask
// Bus left in access so a transfer may follow at once
task x(input w,input [17:0] a,input [31:0] d);
	psel<=1;penable<=0;pwrite<=w;paddr<=a;pwdata<=d;
	@(posedge pclk);
	penable<=1;
	do @(posedge pclk); while (pready!==1);
	q=prdata;
	s=slv;
endtask
task i;psel<=0;penable<=0;@(posedge pclk);endtask
task test_done;
	$display("checks %0d bad %0d",check_count,miscompares);
	if (miscompares==0&&check_count>0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
initial begin #20000;miscompares++;test_done;end
initial begin
	repeat(12) @(posedge pclk);
	presetn<=1;
	x(0,18'h4040,0);c(q,5);
	x(0,18'h4054,0);c(q,0);
	x(1,18'h4040,2);i;c(ge,0);
	x(0,18'h4040,0);c(q,7);c(s,0);
	x(1,18'h4040,0);i;c(ge,1);
	pstrb<=0;x(1,18'h4040,2);pstrb<=4'hF;i;c(ge,1);
	lp.loopback_mode<=1;x(0,18'h4040,0);c(q[3],1);
	i;lp.ev(0);x(0,18'h4054,0);c(q,1);
	i;lp.ev(1);x(0,18'h4054,0);c(q,3);
	x(1,18'h4054,4);x(0,18'h4054,0);c(q,0);
	x(1,18'h4058,1);x(0,18'h4058,0);c(q,1);
	i;c(lr,1);
	x(0,18'h4044,0);c(q,0);c(s,1);
	x(1,18'h4058,0);i;c(lr,0);
	$display("tests done");
	test_done;
end
endmodule // packet_client_loopback_ctrl_bench

//--- test/pkt_ctrl_chk_assertions.sv
`timescale 1ns/1ps
module pkt_ctrl_chk(input wire pclk,presetn,psel,penable,pwrite,input wire [17:0] paddr,input wire [31:0] pwdata,
	input wire [3:0] pstrb,input wire [31:0] prdata,input wire pslverr,input wire loopback_mode,fifo_underflow,fifo_overflow,
	input wire generator_enable,loopback_reset);
default clocking @(posedge pclk);endclocking
default disable iff (!presetn);
// Writes land at the access edge, reads load at setup
wire w=psel&penable&pwrite&pstrb[0];
wire r=psel&!penable&!pwrite;
AST_GEN: assert property (w&&paddr==18'h4040 |=> generator_enable==!$past(pwdata[1])) else $error("gen");
AST_GON: assert property (w&&paddr==18'h4040&&!pwdata[1] ##1 !w |-> generator_enable[*2]) else $error("on");
AST_MODE: assert property (r&&paddr==18'h4040 |=> prdata[3]==$past(loopback_mode)) else $error("mode");
AST_UFL: assert property (r&&paddr==18'h4054&&$past(fifo_underflow&!loopback_reset) |=> prdata[0]) else $error("ufl");
AST_OFL: assert property (r&&paddr==18'h4054&&$past(fifo_overflow&!loopback_reset) |=> prdata[1]) else $error("ofl");
AST_CLR: assert property (w&&paddr==18'h4054&&pwdata[2]&&!fifo_underflow&&!fifo_overflow ##1 r&&paddr==18'h4054
	&&!fifo_underflow&&!fifo_overflow |=> prdata[1:0]==2'h0) else $error("clr");
AST_LBR: assert property (w&&paddr==18'h4058 |=> loopback_reset==$past(pwdata[0])) else $error("lbr");
AST_RST: assert property ($rose(presetn) |-> generator_enable&&!loopback_reset) else $error("rst");
AST_SLV: assert property (psel&&penable&&paddr[17:2]!=16'h1010&&paddr[17:2]!=16'h1015&&paddr[17:2]!=16'h1016
	|-> pslverr) else $error("slv");
AST_STRB: assert property (psel&&penable&&pwrite&&!pstrb[0]&&paddr[17:2]==16'h1010
	|=> $stable(generator_enable)) else $error("strb");
endmodule // pkt_ctrl_chk
bind packet_client_loopback_ctrl pkt_ctrl_chk chk(.*);
